// ===== inc/complementary_three_phase_pwm_regs.svh
// Register map, reset values and timing counts of the PWM block.
// Assumes byte addresses on an AXI4-Lite bus with 32-bit data.
`ifndef COMPLEMENTARY_THREE_PHASE_PWM_REGS_SVH
`define COMPLEMENTARY_THREE_PHASE_PWM_REGS_SVH

`define ADDR_CTRL 8'h00
`define ADDR_PERIOD 8'h04
`define ADDR_DEAD 8'h08
`define ADDR_BUF1 8'h0C
`define ADDR_BUF2 8'h10
`define ADDR_BUF3 8'h14
`define ADDR_ACT1 8'h18
`define ADDR_ACT2 8'h1C
`define ADDR_ACT3 8'h20
`define ADDR_STATUS 8'h24
`define ADDR_MASK 8'h28
`define ADDR_COUNT 8'h2C

`define CTRL_RUN_BIT 0
`define STAT_MATCH_BIT 0
`define STAT_UNDER_BIT 1

`define PERIOD_RST 16'h0C7E
`define DEAD_RST 16'h0190
`define DUTY_RST 16'h031F
`define MASK_RST 2'h0

`define REF_CLK_MHZ 100
`define COUNT_CLK_MHZ 16
`define ACC_STEP 8'(`COUNT_CLK_MHZ)
`define ACC_MOD 8'(`REF_CLK_MHZ)
`define PWM_PERIOD_US 350

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== inc/complementary_three_phase_pwm_pkg.sv
// Types shared by the complementary PWM block.
// Assumes the register header is included alongside.
package complementary_three_phase_pwm_pkg;

  typedef struct packed {
    logic [2:0] normal;
    logic [2:0] counter;
    logic toggle;
  } pwmPins_t;

  typedef enum {DIR_UP, DIR_DOWN} countDir_t;

endpackage : complementary_three_phase_pwm_pkg

// ===== hw/complementary_three_phase_pwm.sv
// Three-phase complementary PWM with dead time, toggle pin and interrupt.
// Assumes an AXI4-Lite master on ref_clk (100 MHz) and gate drivers on the pins.
//
// Contract
// - Three-phase triangular PWM with dead time between complementary outputs, 350 us period.
// - Phases share one waveform while their active duties agree.
// - Separate toggle pin inverts once every half PWM period.
// - Period is twice count clock times period compare plus two minus dead time.
// - Counters run from a 16 MHz count source.
// - First counter keeps counting through its period compare match.
// - Second counter keeps counting through its phase two compare match.
// - Each phase duty compare has its own software-written buffer register.
// - Buffered duties move to active compares at second counter underflow and while the counter is stopped.
// - All seven outputs are active low and start high before counting.
// - Output is enabled on all seven pins.
// - No forced cutoff input can drive outputs inactive.
// - Interrupt request at each first counter period compare match.
// - Normal-phase inactive interval at each period edge lasts twice duty plus two count clocks.
// - Zero duty holds normal phases low and counter phases high.
// - Duty above period compare holds normal phases high, counter phases low.
`include "complementary_three_phase_pwm_regs.svh"
`timescale 1ns/100ps

module complementary_three_phase_pwm
  import complementary_three_phase_pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Gate driver pins, active low
  output pwmPins_t pins,
  // Interrupt, level
  output logic irq
);

  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeStrb

  // Returns {normal level, counter level}; 1 is the inactive high level
  function automatic logic [1:0] phaseLevel(input logic [15:0] c,
                                            input logic [15:0] n,
                                            input logic [15:0] d,
                                            input logic [15:0] p);
    logic [16:0] sum;
    sum = {1'b0, c} + {1'b0, d};
    if (n == 16'h0000) begin
      phaseLevel = 2'b01;
    end else if (n > p) begin
      phaseLevel = 2'b10;
    end else begin
      // Gap between the two compares is the dead time
      phaseLevel = {c <= n, sum > {1'b0, n}};
    end
  endfunction : phaseLevel

  logic runQ;
  logic [15:0] periodQ;
  logic [15:0] deadQ;
  logic [15:0] bufQ [3];
  logic [15:0] actQ [3];
  logic [1:0] statQ;
  logic [1:0] maskQ;

  // Count clock enable from 100 MHz by a phase accumulator
  logic [6:0] accQ;
  logic tickQ;
  logic [7:0] accSum;
  assign accSum = {1'b0, accQ} + `ACC_STEP;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      accQ <= 7'h00;
      tickQ <= 1'b0;
    end else if (accSum >= `ACC_MOD) begin
      accQ <= 7'(accSum - `ACC_MOD);
      tickQ <= 1'b1;
    end else begin
      accQ <= accSum[6:0];
      tickQ <= 1'b0;
    end
  end

  // Triangle counter; first counter equals it plus dead time
  logic [15:0] cQ;
  countDir_t dirQ;
  logic [15:0] halfMax;
  logic matchEv;
  logic underEv;
  assign halfMax = 16'(periodQ + 16'h0001 - deadQ);
  assign matchEv = tickQ && runQ && dirQ == DIR_UP && cQ >= halfMax;
  assign underEv = tickQ && runQ && dirQ == DIR_DOWN && cQ == 16'h0000;

  always_ff @(posedge ref_clk) begin
    if (reset || !runQ) begin
      cQ <= 16'h0000;
      dirQ <= DIR_UP;
    end else if (tickQ) begin
      case (dirQ)
        DIR_UP: begin
          // Match turns the count, never clears it
          if (cQ >= halfMax) begin
            dirQ <= DIR_DOWN;
          end else begin
            cQ <= 16'(cQ + 16'h0001);
          end
        end
        DIR_DOWN: begin
          if (cQ == 16'h0000) begin
            dirQ <= DIR_UP;
          end else begin
            cQ <= 16'(cQ - 16'h0001);
          end
        end
        default: begin
          dirQ <= DIR_UP;
        end
      endcase
    end
  end

  // Double-buffered duties; stopped counter lets buffers pass straight through
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        actQ[i] <= `DUTY_RST;
      end
    end else if (!runQ || underEv) begin
      for (int i = 0; i < 3; i++) begin
        actQ[i] <= bufQ[i];
      end
    end
  end

  // Pins: no cutoff input exists, only run gates them
  logic [1:0] lvl [3];
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lvl[i] = phaseLevel(cQ, actQ[i], deadQ, periodQ);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !runQ) begin
      pins <= '1;
    end else begin
      for (int i = 0; i < 3; i++) begin
        pins.normal[i] <= lvl[i][1];
        pins.counter[i] <= lvl[i][0];
      end
      if (matchEv || underEv) begin
        pins.toggle <= ~pins.toggle;
      end
    end
  end

  // AXI4-Lite write channel
  logic awGotQ;
  logic wGotQ;
  logic [7:0] awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0] wStrbQ;
  logic doWrite;
  assign doWrite = awGotQ && wGotQ && !bvalid;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      awready <= 1'b1;
      wready <= 1'b1;
      awGotQ <= 1'b0;
      wGotQ <= 1'b0;
      awAddrQ <= 8'h00;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awGotQ <= 1'b1;
        awAddrQ <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wGotQ <= 1'b1;
        wDataQ <= wdata;
        wStrbQ <= wstrb;
      end
      if (doWrite) begin
        awGotQ <= 1'b0;
        wGotQ <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awAddrQ <= `ADDR_COUNT) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  logic [31:0] wm;
  assign wm = mergeStrb(32'h00000000, wDataQ, wStrbQ);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      runQ <= 1'b0;
      periodQ <= `PERIOD_RST;
      deadQ <= `DEAD_RST;
      maskQ <= `MASK_RST;
      for (int i = 0; i < 3; i++) begin
        bufQ[i] <= `DUTY_RST;
      end
    end else if (doWrite) begin
      case (awAddrQ)
        `ADDR_CTRL: if (wStrbQ[0]) runQ <= wm[`CTRL_RUN_BIT];
        `ADDR_PERIOD: periodQ <= mergeStrb({16'h0000, periodQ}, wDataQ, wStrbQ)
                                 [15:0];
        `ADDR_DEAD: deadQ <= mergeStrb({16'h0000, deadQ}, wDataQ, wStrbQ)[15:0];
        `ADDR_BUF1: bufQ[0] <= mergeStrb({16'h0000, bufQ[0]}, wDataQ, wStrbQ)
                                 [15:0];
        `ADDR_BUF2: bufQ[1] <= mergeStrb({16'h0000, bufQ[1]}, wDataQ, wStrbQ)
                                 [15:0];
        `ADDR_BUF3: bufQ[2] <= mergeStrb({16'h0000, bufQ[2]}, wDataQ, wStrbQ)
                                 [15:0];
        `ADDR_MASK: if (wStrbQ[0]) maskQ <= wm[1:0];
        default: begin
        end
      endcase
    end
  end

  // AXI4-Lite read channel, one cycle to rvalid
  logic [31:0] rdMux;
  logic rdOk;
  logic rdStat;
  assign rdStat = arvalid && arready && {araddr[7:2], 2'b00} == `ADDR_STATUS;

  always_comb begin
    rdOk = 1'b1;
    case ({araddr[7:2], 2'b00})
      `ADDR_CTRL: rdMux = {31'h0, runQ};
      `ADDR_PERIOD: rdMux = {16'h0000, periodQ};
      `ADDR_DEAD: rdMux = {16'h0000, deadQ};
      `ADDR_BUF1: rdMux = {16'h0000, bufQ[0]};
      `ADDR_BUF2: rdMux = {16'h0000, bufQ[1]};
      `ADDR_BUF3: rdMux = {16'h0000, bufQ[2]};
      `ADDR_ACT1: rdMux = {16'h0000, actQ[0]};
      `ADDR_ACT2: rdMux = {16'h0000, actQ[1]};
      `ADDR_ACT3: rdMux = {16'h0000, actQ[2]};
      `ADDR_STATUS: rdMux = {30'h0, statQ};
      `ADDR_MASK: rdMux = {30'h0, maskQ};
      `ADDR_COUNT: rdMux = {15'h0, dirQ == DIR_DOWN, cQ};
      default: begin
        rdMux = 32'h00000000;
        rdOk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Sticky events; a new event wins over the read that clears
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      statQ <= 2'b00;
    end else begin
      statQ <= (rdStat ? 2'b00 : statQ) | {underEv, matchEv};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(statQ & maskQ);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Phases share a waveform while their active duties agree
  property p_same_phase;
    runQ && actQ[0] == actQ[1] && actQ[1] == actQ[2] |=>
      pins.normal inside {3'b000, 3'b111} && pins.counter inside {3'b000, 3'b111};
  endproperty
  a_same_phase: assert property (p_same_phase) else $error("phases differ");

  property p_dead_gap;
    !(pins.normal[0] == 1'b0 && pins.counter[0] == 1'b0);
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("both phases active");

  property p_idle_high;
    !runQ |=> pins == 7'h7F;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("pins not idle high");

  property p_toggle_half;
    runQ && $past(runQ) && !$past(matchEv) && !$past(underEv) |-> $stable(pins.toggle);
  endproperty
  a_toggle_half: assert property (p_toggle_half) else $error("toggle moved");

  property p_tick_rate;
    tickQ |=> !tickQ ##1 !tickQ ##1 !tickQ ##1 !tickQ ##1 !tickQ;
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("count tick too fast");

  property p_count_bound;
    runQ && dirQ == DIR_UP && cQ < halfMax && $stable(halfMax) |=> cQ <= halfMax;
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("counter overrun");

  property p_xfer_only;
    runQ && !underEv |=> actQ[0] == $past(actQ[0]) && actQ[2] == $past(actQ[2]);
  endproperty
  a_xfer_only: assert property (p_xfer_only) else $error("early transfer");

  property p_xfer_take;
    underEv |=> actQ[1] == $past(bufQ[1]);
  endproperty
  a_xfer_take: assert property (p_xfer_take) else $error("transfer missed");

  property p_match_irq;
    matchEv && maskQ[0] |=> ##1 irq;
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("no interrupt");

  property p_zero_duty;
    runQ && actQ[2] == 16'h0000 |=> !runQ || (pins.normal[2] == 1'b0 && pins.counter[2] == 1'b1);
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty not low");

  property p_over_duty;
    runQ && actQ[1] > periodQ |=> !runQ || (pins.counter[1] == 1'b0 && pins.normal[1] == 1'b1);
  endproperty
  a_over_duty: assert property (p_over_duty) else $error("over duty wrong");

endmodule : complementary_three_phase_pwm

// ===== bench/gate_driver_model.sv
// Gate driver model: measures pin spans and watches for shoot-through.
// Assumes the pins of the PWM block, sampled on ref_clk.
`timescale 1ns/100ps

module gate_driver_model
  import complementary_three_phase_pwm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Pins from the block
  input wire pwmPins_t pins,
  // Last measured spans, in ref_clk cycles
  output logic [31:0] normalLowSpan,
  output logic [31:0] counterHighSpan,
  output logic [31:0] toggleSpan,
  // Both switches of one leg on at once
  output logic shootSeen
);
  pwmPins_t prev;
  logic [31:0] nCnt;
  logic [31:0] cCnt;
  logic [31:0] tCnt;

  // Only phase one is timed; the block's assertions check the phases match
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prev <= 7'h7F;
      nCnt <= 32'h0;
      cCnt <= 32'h0;
      tCnt <= 32'h0;
      normalLowSpan <= 32'h0;
      counterHighSpan <= 32'h0;
      toggleSpan <= 32'h0;
      shootSeen <= 1'b0;
    end else begin
      prev <= pins;
      nCnt <= (pins.normal[0] != prev.normal[0]) ? 32'h1 : nCnt + 32'h1;
      cCnt <= (pins.counter[0] != prev.counter[0]) ? 32'h1 : cCnt + 32'h1;
      tCnt <= (pins.toggle != prev.toggle) ? 32'h1 : tCnt + 32'h1;
      if (pins.normal[0] && !prev.normal[0]) begin
        normalLowSpan <= nCnt;
      end
      if (!pins.counter[0] && prev.counter[0]) begin
        counterHighSpan <= cCnt;
      end
      if (pins.toggle != prev.toggle) begin
        toggleSpan <= tCnt;
      end
      // Sticky, a single overlapping cycle would burn a leg
      if (|(~pins.normal & ~pins.counter)) begin
        shootSeen <= 1'b1;
      end
    end
  end
endmodule : gate_driver_model

// ===== bench/testbench.sv
// Self-checking bench for the complementary PWM block.
// Assumes the block alone on ref_clk with the gate driver model on its pins.
`include "complementary_three_phase_pwm_regs.svh"
`timescale 1ns/100ps

module testbench
  import complementary_three_phase_pwm_pkg::*;
;
  typedef struct {string nm; logic [33:0] v;} note_t;
  localparam int H = `PERIOD_RST + 2 - `DEAD_RST;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  pwmPins_t pins;
  logic [31:0] nLow, cHigh, tSpan;
  logic shoot;
  logic [15:0] r1;
  int err_total = 0;
  int n_checks = 0;
  note_t expQ[$];

  complementary_three_phase_pwm uut (.ref_clk(ref_clk), .reset(reset), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pins(pins), .irq(irq));
  gate_driver_model drv (.ref_clk(ref_clk), .reset(reset), .pins(pins),
    .normalLowSpan(nLow), .counterHighSpan(cHigh), .toggleSpan(tSpan), .shootSeen(shoot));

  always #5 ref_clk = ~ref_clk;

  function automatic logic [33:0] cyc(input int ticks);
    return 34'(ticks * `REF_CLK_MHZ / `COUNT_CLK_MHZ);
  endfunction : cyc

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic axWrite(input string nm, input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] r);
    int t;
    expQ.push_back('{nm, {32'h0, r}});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axWrite

  task automatic axRead(input string nm, input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    int t;
    expQ.push_back('{nm, {d, r}});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axRead

  task automatic waitToggle;
    logic tg;
    tg = pins.toggle;
    for (int t = 0; t < 20000 && pins.toggle === tg; t++) @(posedge ref_clk);
  endtask : waitToggle

  // Answers arrive in request order, one transfer at a time
  always @(posedge ref_clk) begin
    note_t note;
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (expQ.size() > 0) begin
        note = expQ.pop_front();
        chk(note.nm, note.v, (bvalid && bready) ? {32'h0, bresp} : {rdata, rresp});
      end
    end
  end

  initial begin
    repeat (95000) @(posedge ref_clk);
    err_total++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    results();
  end

  initial begin
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    void'($urandom(26));
    r1 = 16'($urandom_range(3198, 1));
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk("pins idle", 34'h7F, 34'(pins));
    chk("irq idle", 34'h0, 34'(irq));
    axRead("period", `ADDR_PERIOD, 32'(`PERIOD_RST), `RESP_OKAY);
    axRead("dead", `ADDR_DEAD, 32'(`DEAD_RST), `RESP_OKAY);
    axRead("act1", `ADDR_ACT1, 32'(`DUTY_RST), `RESP_OKAY);
    axWrite("mask", `ADDR_MASK, 32'h1 << `STAT_MATCH_BIT, `RESP_OKAY);
    axWrite("run", `ADDR_CTRL, 32'h1 << `CTRL_RUN_BIT, `RESP_OKAY);
    for (int t = 0; t < 20000 && irq !== 1'b1; t++) @(posedge ref_clk);
    chk("irq at match", 34'h1, 34'(irq));
    chk("normal at top", 34'h0, 34'(pins.normal));
    chk("counter at top", 34'h7, 34'(pins.counter));
    axRead("status", `ADDR_STATUS, 32'h1 << `STAT_MATCH_BIT, `RESP_OKAY);
    @(posedge ref_clk);
    chk("irq cleared", 34'h0, 34'(irq));
    // New duties go in after the match interrupt
    axWrite("buf1", `ADDR_BUF1, 32'(r1), `RESP_OKAY);
    axWrite("buf2", `ADDR_BUF2, 32'(`PERIOD_RST) + 32'h1, `RESP_OKAY);
    axWrite("buf3", `ADDR_BUF3, 32'h0, `RESP_OKAY);
    axRead("act1 held", `ADDR_ACT1, 32'(`DUTY_RST), `RESP_OKAY);
    waitToggle();
    repeat (5) @(posedge ref_clk);
    chk("toggle span", cyc(H), 34'(tSpan));
    chk("normal low", cyc(2 * (H - `DUTY_RST - 1)), 34'(nLow));
    chk("counter high", cyc(2 * (H - 1 - `DUTY_RST + `DEAD_RST)), 34'(cHigh));
    chk("irq masked", 34'h0, 34'(irq));
    axRead("status under", `ADDR_STATUS, 32'h1 << `STAT_UNDER_BIT, `RESP_OKAY);
    axRead("act1 new", `ADDR_ACT1, 32'(r1), `RESP_OKAY);
    axRead("act2 new", `ADDR_ACT2, 32'(`PERIOD_RST) + 32'h1, `RESP_OKAY);
    axRead("act3 new", `ADDR_ACT3, 32'h0, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      repeat (8000) @(posedge ref_clk);
      chk("zero duty leg", 34'h1, 34'({pins.normal[2], pins.counter[2]}));
      chk("full duty leg", 34'h2, 34'({pins.normal[1], pins.counter[1]}));
    end
    axWrite("unmapped write", 8'h30, 32'h5A, `RESP_SLVERR);
    axWrite("read-only write", `ADDR_ACT1, 32'h5A, `RESP_OKAY);
    axRead("act1 kept", `ADDR_ACT1, 32'(r1), `RESP_OKAY);
    axRead("unmapped read", 8'h30, 32'h0, `RESP_SLVERR);
    chk("no overlap", 34'h0, 34'(shoot));
    chk("notes left", 34'h0, 34'(expQ.size()));
    results();
  end
endmodule : testbench
